// ### hw/dsapc_pkg.sv
// ****************************************************************************
// Shared constants and types of the dual converter serial and power control.
// ****************************************************************************
package dsapc_pkg;

  // **************************************************************************
  // Widths.
  // **************************************************************************
  localparam int RESULT_W = 14;  // Width of one converter result.
  localparam int CNT_W    = 6;   // Width of the serial clock falling edge counter.
  localparam int WAKE_W   = 18;  // Width of the wake delay counter.

  // **************************************************************************
  // Falling edge counts that mark points of a frame.
  // **************************************************************************
  localparam logic [CNT_W-1:0] FALL_GLITCH = 6'h02;  // Below this a rise is a glitch.
  localparam logic [CNT_W-1:0] FALL_KEEP   = 6'h0a;  // From this the device stays powered.
  localparam logic [CNT_W-1:0] FALL_WORD   = 6'h10;  // One result word is complete.
  localparam logic [CNT_W-1:0] FALL_DUAL   = 6'h20;  // Both results have been shifted.
  localparam logic [3:0]       LEAD_BITS   = 4'h2;   // Leading zeros of each word.
  localparam logic [3:0]       LAST_INDEX  = 4'hf;   // Bit index base of a word.

  // **************************************************************************
  // Timing constants.
  // **************************************************************************
  localparam int CLK_PERIOD_NS   = 40;   // Period of the reference clock.
  localparam int PARTIAL_WAKE_NS = 200;  // Wake delay from partial power-down.
  localparam int FULL_WAKE_MS    = 6;    // Full wake delay from full power-down.
  localparam int PARTIAL_WAKE_CYC = (PARTIAL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WAKE_CYC    = (FULL_WAKE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // **************************************************************************
  // Types.
  // **************************************************************************
  // Power state of the converter pair.
  typedef enum logic [1:0] {
    DSAPC_NORMAL,
    DSAPC_PARTIAL,
    DSAPC_FULL
  } dsapc_mode_t;

  // One three-state serial data line: level and active-low output enable.
  typedef struct packed {
    logic data;
    logic oe_n;
  } dsapc_line_t;

endpackage : dsapc_pkg

// ### hw/dsapc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************************
// Two-stage synchroniser with edge detection for one pin.
// ****************************************************************************
module dsapc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1  // Level held by all stages in reset.
) (
  // Clock and reset.
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Pin and synchronised results.
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_reg;   // First stage, read only by the second.
  logic sync_reg;   // Second stage, the usable level.
  logic prev_reg;   // Delayed level for edge detection.
  logic meta_next;  // Next first stage.
  logic sync_next;  // Next second stage.
  logic prev_next;  // Next delayed level.

  // Next values of the three stages.
  always_comb begin
    meta_next = i_pin;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // Register the stages.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      prev_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Level and one-cycle edge pulses, taken from the second stage onward.
  assign o_level = sync_reg;
  assign o_rise  = sync_reg & ~prev_reg;
  assign o_fall  = ~sync_reg & prev_reg;

endmodule  // dsapc_pin_sync

`default_nettype wire

// ### hw/dsapc_serial_power.sv
`timescale 1ns/100ps
`default_nettype none

module dsapc_serial_power #(
  parameter int FULL_WAKE_CYCLES = dsapc_pkg::FULL_WAKE_CYC  // Wake delay from full power-down.
) (
  // Clock and reset.
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_n,
  // Serial pins from the host.
  input  wire logic                        i_cs_n,
  input  wire logic                        i_sclk,
  // Results of the converter cores.
  input  wire logic [dsapc_pkg::RESULT_W-1:0] i_sample_a,
  input  wire logic [dsapc_pkg::RESULT_W-1:0] i_sample_b,
  // Serial data lines.
  output dsapc_pkg::dsapc_line_t           o_serial_out_a,
  output dsapc_pkg::dsapc_line_t           o_serial_out_b,
  // Converter state.
  output dsapc_pkg::dsapc_mode_t           o_power_mode,
  output logic                             o_powered,
  output logic                             o_track
);
  import dsapc_pkg::*;

  // **************************************************************************
  // Pin synchronisers.
  // **************************************************************************
  logic cs_n_lvl;   // Synchronised select level.
  logic cs_rise;    // Select rose this cycle.
  logic cs_fall;    // Select fell this cycle.
  logic sclk_rise;  // Serial clock rose this cycle.
  logic sclk_fall;  // Serial clock fell this cycle.

  dsapc_pin_sync #(.RESET_LEVEL(1'b1)) u_cs_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_cs_n),
    .o_level   (cs_n_lvl),
    .o_rise    (cs_rise),
    .o_fall    (cs_fall)
  );

  dsapc_pin_sync #(.RESET_LEVEL(1'b1)) u_sclk_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_sclk),
    .o_level   (),
    .o_rise    (sclk_rise),
    .o_fall    (sclk_fall)
  );

  // **************************************************************************
  // Bit selection.
  // **************************************************************************
  // Picks the bit shown after a given count of falling edges.
  function automatic logic serial_bit(input logic [CNT_W-1:0]    cnt,
                                      input logic [RESULT_W-1:0] first,
                                      input logic [RESULT_W-1:0] second);
    logic [3:0] idx;
    idx = LAST_INDEX - cnt[3:0];
    if (cnt[3:0] < LEAD_BITS) begin
      // Leading zeros of either word, the second pair leading the second word.
      serial_bit = 1'b0;
    end else if (cnt[4]) begin
      serial_bit = second[idx];
    end else begin
      serial_bit = first[idx];
    end
  endfunction

  // **************************************************************************
  // Frame and power state.
  // **************************************************************************
  dsapc_mode_t         mode_reg,     mode_next;      // Power state.
  logic [WAKE_W-1:0]   wake_reg,     wake_next;      // Remaining wake delay.
  logic                waking_reg,   waking_next;    // A wake frame is in progress.
  logic [CNT_W-1:0]    cnt_reg,      cnt_next;       // Falling edges in this frame.
  logic [CNT_W-1:0]    cnt_inc;                      // Count after one more edge.
  dsapc_line_t         line_a_reg,   line_a_next;    // Data line A.
  dsapc_line_t         line_b_reg,   line_b_next;    // Data line B.
  logic                track_reg,    track_next;     // Sampling stage tracks.
  logic                powered_reg,  powered_next;   // Fully powered.
  logic [RESULT_W-1:0] sample_a_reg, sample_a_next;  // Held sample A under conversion.
  logic [RESULT_W-1:0] sample_b_reg, sample_b_next;  // Held sample B under conversion.
  logic [RESULT_W-1:0] prev_a_reg,   prev_a_next;    // Last completed result A.
  logic [RESULT_W-1:0] prev_b_reg,   prev_b_next;    // Last completed result B.
  logic [RESULT_W-1:0] shadow_a_reg, shadow_a_next;  // Result A being shifted out.
  logic [RESULT_W-1:0] shadow_b_reg, shadow_b_next;  // Result B being shifted out.

  // Next state of the whole frame and power logic.
  always_comb begin
    mode_next     = mode_reg;
    wake_next     = wake_reg;
    waking_next   = waking_reg;
    cnt_next      = cnt_reg;
    cnt_inc       = cnt_reg + 6'h01;
    line_a_next   = line_a_reg;
    line_b_next   = line_b_reg;
    track_next    = track_reg;
    sample_a_next = sample_a_reg;
    sample_b_next = sample_b_reg;
    prev_a_next   = prev_a_reg;
    prev_b_next   = prev_b_reg;
    shadow_a_next = shadow_a_reg;
    shadow_b_next = shadow_b_reg;
    // The wake delay runs down on the reference clock alone.
    if (wake_reg != '0) begin
      wake_next = wake_reg - 18'h00001;
    end
    if (cs_fall) begin
      // Hold, sample, drive the first leading zero and start converting.
      cnt_next      = '0;
      track_next    = 1'b0;
      sample_a_next = i_sample_a;
      sample_b_next = i_sample_b;
      shadow_a_next = prev_a_reg;
      shadow_b_next = prev_b_reg;
      line_a_next   = '{data: 1'b0, oe_n: 1'b0};
      line_b_next   = '{data: 1'b0, oe_n: 1'b0};
      if (mode_reg == DSAPC_PARTIAL) begin
        wake_next   = WAKE_W'(PARTIAL_WAKE_CYC);
        waking_next = 1'b1;
      end else if (mode_reg == DSAPC_FULL) begin
        wake_next   = WAKE_W'(FULL_WAKE_CYCLES);
        waking_next = 1'b1;
      end
    end else if (cs_rise) begin
      // Abort the conversion and release both lines at once.
      line_a_next = '{data: 1'b0, oe_n: 1'b1};
      line_b_next = '{data: 1'b0, oe_n: 1'b1};
      if (cnt_reg < FALL_GLITCH) begin
        // A glitch: keep the mode, and a started wake collapses again.
        if (mode_reg != DSAPC_NORMAL) begin
          waking_next = 1'b0;
          wake_next   = '0;
        end
      end else if (cnt_reg < FALL_KEEP) begin
        // Power-down takes effect here without any further clock pulse.
        mode_next   = (mode_reg == DSAPC_NORMAL) ? DSAPC_PARTIAL : DSAPC_FULL;
        waking_next = 1'b0;
        wake_next   = '0;
      end
      // Powered devices go back to tracking; powered-down ones stay in hold.
      track_next = (mode_next == DSAPC_NORMAL);
    end else if (!cs_n_lvl) begin
      if (sclk_fall && (cnt_reg != FALL_DUAL)) begin
        cnt_next = cnt_inc;
        // Past the tenth falling edge the device stays powered.
        if (cnt_inc == FALL_KEEP) begin
          mode_next   = DSAPC_NORMAL;
          waking_next = 1'b0;
        end
        // The conversion completes and becomes the next frame's result.
        if (cnt_inc == FALL_WORD) begin
          prev_a_next = sample_a_reg;
          prev_b_next = sample_b_reg;
        end
        if (cnt_inc == FALL_DUAL) begin
          // A released line shows low, just as after a select rise.
          line_a_next = '{data: 1'b0, oe_n: 1'b1};
          line_b_next = '{data: 1'b0, oe_n: 1'b1};
        end else begin
          // Data change on falling edges, so rising-edge capture also works.
          line_a_next.data = serial_bit(cnt_inc, shadow_a_reg, shadow_b_reg);
          line_b_next.data = serial_bit(cnt_inc, shadow_b_reg, shadow_a_reg);
        end
      end
      // Waking from partial power-down the stage tracks after any first edge.
      if (waking_reg && (mode_reg == DSAPC_PARTIAL) && (sclk_fall || sclk_rise)) begin
        track_next = 1'b1;
      end
      // After the sixteenth falling edge the next rising edge releases the hold.
      if (sclk_rise && (cnt_reg >= FALL_WORD)) begin
        track_next = 1'b1;
      end
    end
    powered_next = ((mode_next == DSAPC_NORMAL) || waking_next) && (wake_next == '0);
  end

  // Register the frame and power state.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mode_reg     <= DSAPC_NORMAL;
      wake_reg     <= '0;
      waking_reg   <= 1'b0;
      cnt_reg      <= '0;
      line_a_reg   <= '{data: 1'b0, oe_n: 1'b1};
      line_b_reg   <= '{data: 1'b0, oe_n: 1'b1};
      track_reg    <= 1'b1;
      powered_reg  <= 1'b1;
      sample_a_reg <= '0;
      sample_b_reg <= '0;
      prev_a_reg   <= '0;
      prev_b_reg   <= '0;
      shadow_a_reg <= '0;
      shadow_b_reg <= '0;
    end else begin
      mode_reg     <= mode_next;
      wake_reg     <= wake_next;
      waking_reg   <= waking_next;
      cnt_reg      <= cnt_next;
      line_a_reg   <= line_a_next;
      line_b_reg   <= line_b_next;
      track_reg    <= track_next;
      powered_reg  <= powered_next;
      sample_a_reg <= sample_a_next;
      sample_b_reg <= sample_b_next;
      prev_a_reg   <= prev_a_next;
      prev_b_reg   <= prev_b_next;
      shadow_a_reg <= shadow_a_next;
      shadow_b_reg <= shadow_b_next;
    end
  end

  // Outputs straight from the registers.
  assign o_serial_out_a = line_a_reg;
  assign o_serial_out_b = line_b_reg;
  assign o_power_mode   = mode_reg;
  assign o_powered      = powered_reg;
  assign o_track        = track_reg;

  // **************************************************************************
  // Assertions.
  // **************************************************************************
  glitch_keep_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cs_rise && (cnt_reg < FALL_GLITCH) && (mode_reg == DSAPC_NORMAL))
      |=> (mode_reg == DSAPC_NORMAL))
    else $error("Glitch on select changed the power mode.");

  partial_entry_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cs_rise && (cnt_reg >= FALL_GLITCH) && (cnt_reg < FALL_KEEP) && (mode_reg == DSAPC_NORMAL))
      |=> (mode_reg == DSAPC_PARTIAL) && !o_track)
    else $error("Interrupted frame did not enter partial power-down.");

  full_entry_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cs_rise && (cnt_reg >= FALL_GLITCH) && (cnt_reg < FALL_KEEP) && (mode_reg == DSAPC_PARTIAL))
      |=> (mode_reg == DSAPC_FULL) && !o_powered)
    else $error("Second interrupted frame did not enter full power-down.");

  keep_power_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cs_rise && (cnt_reg >= FALL_KEEP) && (cnt_reg < FALL_WORD))
      |=> (mode_reg == DSAPC_NORMAL) && line_a_reg.oe_n && line_b_reg.oe_n)
    else $error("Late abort did not stay powered with lines released.");

  rise_release_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cs_rise |=> (line_a_reg.oe_n && line_b_reg.oe_n))
    else $error("Select rise left a data line driven.");

  dual_end_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!cs_n_lvl && !cs_rise && !cs_fall && sclk_fall && (cnt_reg == FALL_DUAL - 6'h01))
      |=> (line_a_reg.oe_n && line_b_reg.oe_n))
    else $error("Dual readout did not release at the last falling edge.");

  lead_zero_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cs_fall |=> (!line_a_reg.oe_n && !line_a_reg.data && !line_b_reg.oe_n && !o_track))
    else $error("Select fall did not hold and drive a leading zero.");

  part_wake_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cs_fall && (mode_reg == DSAPC_PARTIAL)) ##1 (!cs_n_lvl && !cs_rise)[*6] |-> o_powered)
    else $error("Partial wake took longer than its delay.");

  result_latency_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    cs_fall |=> ((shadow_a_reg == $past(prev_a_reg)) && (shadow_b_reg == $past(prev_b_reg))))
    else $error("Frame does not carry the previous result.");

  swap_word_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!line_a_reg.oe_n && (cnt_reg == 6'h14))
      |-> ((line_a_reg.data == shadow_b_reg[11]) && (line_b_reg.data == shadow_a_reg[11])))
    else $error("Second word is not the other converter's result.");

  track_return_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (!cs_n_lvl && !cs_rise && !cs_fall && sclk_rise && (cnt_reg >= FALL_WORD)) |=> o_track)
    else $error("Stage did not return to track after the word.");

endmodule  // dsapc_serial_power

`default_nettype wire

// ### verif/dsapc_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************************
// Host side of the serial link: drives select and serial clock, reads lines.
// ****************************************************************************
module dsapc_host_model (
  // Bench clock; the serial pins change just after its rising edge.
  input  wire logic                  i_ref_clk,
  // Serial pins towards the converter.
  output var  logic                  o_cs_n,
  output var  logic                  o_sclk,
  // Serial data lines coming back.
  input  wire dsapc_pkg::dsapc_line_t i_serial_out_a,
  input  wire dsapc_pkg::dsapc_line_t i_serial_out_b
);
  import dsapc_pkg::*;

  int          cnt;           // Serial clock falls issued in the current frame.
  dsapc_line_t cap_a [0:32];  // Line A as seen just before each fall, by count.
  dsapc_line_t cap_b [0:32];  // Line B as seen just before each fall, by count.
  dsapc_line_t rcap_a [0:32]; // Line A as seen at each rising edge, by count.

  // Both pins idle high; the serial clock stands still outside frames.
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
  end

  // Waits a number of bench clock cycles.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Records both lines under the current count, as a falling edge reader does.
  task automatic grab();
    if (cnt <= 32) begin
      cap_a[cnt] = i_serial_out_a;
      cap_b[cnt] = i_serial_out_b;
    end
  endtask

  // Lowers select with the serial clock held high, which opens a frame.
  task automatic cs_fall();
    cnt = 0;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    wait_cyc(6);
  endtask

  // Captures the bit on show, then gives one falling serial clock edge.
  task automatic clk_fall();
    @(posedge i_ref_clk);
    grab();
    o_sclk <= 1'b0;
    cnt = cnt + 1;
    wait_cyc(3);
  endtask

  // Returns the serial clock high; each phase lasts four bench cycles.
  // A slow host reads the bit at this rising edge as well.
  task automatic clk_rise();
    @(posedge i_ref_clk);
    if (cnt <= 32) begin
      rcap_a[cnt] = i_serial_out_a;
    end
    o_sclk <= 1'b1;
    wait_cyc(3);
  endtask

  // Raises select without any further clock pulses, then keeps the bus quiet.
  task automatic cs_rise();
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    wait_cyc(8);
  endtask
endmodule  // dsapc_host_model

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************************
// Self-checking bench of the serial readout and power control.
// ****************************************************************************
module tb_top;
  import dsapc_pkg::*;

  localparam int WAKE_CYC = 20;  // Shortened full wake delay for simulation.

  logic                ref_clk = 1'b0;  // Bench clock, 40 ns period.
  logic                rst_n;           // Synchronous reset, active low.
  logic                cs_n;            // Select pin from the host model.
  logic                sclk;            // Serial clock pin from the host model.
  logic [RESULT_W-1:0] sa;              // Core value of converter A.
  logic [RESULT_W-1:0] sb;              // Core value of converter B.
  dsapc_line_t         line_a;          // Serial line A.
  dsapc_line_t         line_b;          // Serial line B.
  dsapc_mode_t         mode;            // Power state seen at the port.
  logic                powered;         // Fully powered flag.
  logic                trk;             // Track or hold of the sampling stage.
  int                  bad_count = 0;   // Mismatches seen.
  int                  n_compared = 0;  // Comparisons made.

  // The clock toggles every half period.
  always #20 ref_clk = ~ref_clk;

  // ****************************************************************************
  // Block under test and the host that drives it.
  // ****************************************************************************
  dsapc_serial_power #(.FULL_WAKE_CYCLES(WAKE_CYC)) dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_sample_a(sa), .i_sample_b(sb), .o_serial_out_a(line_a),
    .o_serial_out_b(line_b), .o_power_mode(mode), .o_powered(powered), .o_track(trk));

  dsapc_host_model host (
    .i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_sclk(sclk),
    .i_serial_out_a(line_a), .i_serial_out_b(line_b));

  // ****************************************************************************
  // Comparison and reporting.
  // ****************************************************************************
  // Compares one bit and reports a mismatch at once.
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Compares the power state.
  task automatic chk_mode(input string what, input dsapc_mode_t exp, input dsapc_mode_t got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Expected level of a line at a count: zeros frame each 14-bit word.
  function automatic logic wbit(input int c, input logic [13:0] r1, input logic [13:0] r2);
    if (c < 2 || (c >= 16 && c < 18) || c >= 32) return 1'b0;
    if (c < 16) return r1[15-c];
    return r2[31-c];
  endfunction

  // Checks a captured frame; without vld only the framing is judged.
  task automatic chk_word(input int n, input logic [13:0] ra, input logic [13:0] rb,
                          input bit vld);
    for (int c = 0; c <= n; c++) begin
      chk_bit("line a enable", c >= 32, host.cap_a[c].oe_n);
      chk_bit("line b enable", c >= 32, host.cap_b[c].oe_n);
      if (vld || c < 2) begin
        chk_bit("line a data", wbit(c, ra, rb), host.cap_a[c].data);
        chk_bit("line b data", wbit(c, rb, ra), host.cap_b[c].data);
      end
      if (vld && c > 0 && c < 32) begin
        chk_bit("line a rising capture", wbit(c, ra, rb), host.rcap_a[c].data);
      end
    end
  endtask

  // One frame of n falls; wk is 0 normal, 1 partial wake, 2 full wake.
  task automatic frame(input int n, input int wk, input dsapc_mode_t em, input logic ep,
                       input logic et);
    host.cs_fall();
    chk_bit("powered at select", wk == 0, powered);
    chk_bit("hold at select", 1'b0, trk);
    for (int k = 0; k < n; k++) begin
      host.clk_fall();
      host.clk_rise();
      if (k == 0) begin
        chk_bit("track after first edge", wk == 1, trk);
      end
      if (k == 0 && wk == 1) begin
        chk_bit("powered after partial wake", 1'b1, powered);
      end
      if (k == 15 && wk == 0) begin
        host.wait_cyc(3);
        chk_bit("track after sixteenth", 1'b1, trk);
      end
    end
    host.wait_cyc(6);
    host.grab();
    host.cs_rise();
    chk_mode("mode after frame", em, mode);
    chk_bit("powered after frame", ep, powered);
    chk_bit("track after frame", et, trk);
    chk_bit("line a released", 1'b1, line_a.oe_n);
    chk_bit("line b released", 1'b1, line_b.oe_n);
  endtask

  // ****************************************************************************
  // Scenarios.
  // ****************************************************************************
  // Plain and dual readout with one sample of latency.
  task automatic sc_readout();
    sa <= 14'h1a5c;
    sb <= 14'h2c3e;
    frame(16, 0, DSAPC_NORMAL, 1'b1, 1'b1);
    chk_word(16, 14'h0000, 14'h0000, 1'b1);
    sa <= 14'h3f01;
    sb <= 14'h0ace;
    frame(32, 0, DSAPC_NORMAL, 1'b1, 1'b1);
    chk_word(32, 14'h1a5c, 14'h2c3e, 1'b1);
  endtask

  // Early rises: a glitch and an abort after the tenth fall.
  task automatic sc_abort();
    frame(1, 0, DSAPC_NORMAL, 1'b1, 1'b1);
    frame(12, 0, DSAPC_NORMAL, 1'b1, 1'b1);
    chk_word(12, 14'h3f01, 14'h0ace, 1'b1);
  endtask

  // Partial, then full power-down, then wake from full power-down.
  task automatic sc_full();
    frame(5, 0, DSAPC_PARTIAL, 1'b0, 1'b0);
    frame(5, 1, DSAPC_FULL, 1'b0, 1'b0);
    frame(16, 2, DSAPC_NORMAL, 1'b1, 1'b1);
    chk_word(16, 14'h0000, 14'h0000, 1'b0);
  endtask

  // Partial power-down, a one-fall glitch frame that leaves it down, then a frame that wakes the device.
  task automatic sc_partial_wake();
    frame(5, 0, DSAPC_PARTIAL, 1'b0, 1'b0);
    frame(1, 1, DSAPC_PARTIAL, 1'b0, 1'b0);
    frame(16, 1, DSAPC_NORMAL, 1'b1, 1'b1);
    chk_word(16, 14'h0000, 14'h0000, 1'b0);
  endtask

  // ****************************************************************************
  // Main sequence and watchdog.
  // ****************************************************************************
  initial begin
    rst_n = 1'b0;
    sa = 14'h0000;
    sb = 14'h0000;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    sc_readout();
    sc_abort();
    sc_full();
    sc_partial_wake();
    finish_test();
  end

  // Cuts a hang short and counts it as a mismatch.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED watchdog expected end of run seen hang");
    finish_test();
  end
endmodule  // tb_top

`default_nettype wire
